/* verilog/sbpa_pkg.sv */
// constants and register map of the six-bit port with analog muxing
// What this block does
// - A pin whose direction bit is 0 is driven from its latch bit, analog or not, unless the master port or the reference output takes it.
// - A pin whose direction bit is 1 reads back its pin level, except that the digital input reads zero while the pin is analog.
// - After reset the pins of converter channels 0 to 4 are analog inputs, and their digital output still works.
// - After reset port bit 4 is a digital input, and the same pin also feeds the timer's external clock.
// - While the comparator reference output is enabled, port bit 2 has neither digital output nor digital input.
// - Port bits 4 and 5 carry master port data lines only when the pin-placement setting is 0 and the package is the larger one.
// - On a pin that carries a master port data line, the master port sets the direction and the direction bit is overridden.
// - Bits 7 and 6 of the pin-level, latch and direction registers read as zero.
// - The analog-select register overlaps a default register at one address and is reached only while watchdog control bit 4 is 1.
// - A direction bit of 1 makes its pin an input and a direction bit of 0 makes it an output.
// - Port bits 5 and 3 to 0 come up analog on any reset, and read as zero on the digital path while analog.
package sbpa_pkg;
	localparam int PORT_W = 6;
	localparam int REG_W = 8;
	localparam int DATA_W = 32;
	localparam int OFS_W = 8;
	// byte addresses of the word registers
	localparam logic [OFS_W-1:0] OFS_PIN = 8'h00;
	localparam logic [OFS_W-1:0] OFS_LAT = 8'h04;
	localparam logic [OFS_W-1:0] OFS_DIR = 8'h08;
	localparam logic [OFS_W-1:0] OFS_SHARED = 8'h0C;
	localparam logic [OFS_W-1:0] OFS_WDT = 8'h10;
	localparam logic [OFS_W-1:0] OFS_CFG = 8'h14;
	// field positions
	localparam int SHSEL_BIT = 4;
	localparam int CFG_CREF_BIT = 0;
	localparam int CFG_PLACE_BIT = 1;
	localparam int TMR_PIN = 4;
	localparam int CREF_PIN = 2;
	localparam int PMP_PIN_A = 4;
	localparam int PMP_PIN_B = 5;
	localparam int ANA_CH_HI = 4;
	// reset values
	localparam logic [PORT_W-1:0] LAT_RST = 6'h00;
	localparam logic [PORT_W-1:0] DIR_RST = 6'h3F;
	localparam logic [REG_W-1:0] ANA_RST = 8'h00;
	localparam logic [REG_W-1:0] DEF_RST = 8'h00;
	localparam logic [REG_W-1:0] WDT_RST = 8'h00;
	localparam logic [REG_W-1:0] CFG_RST = 8'h00;
	// implemented select bits: bit 7 and channels 4..0
	localparam logic [REG_W-1:0] ANA_MASK = 8'h9F;
	localparam logic [REG_W-1:0] WDT_MASK = 8'h10;
	localparam logic [REG_W-1:0] CFG_MASK = 8'h03;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* verilog/sbpa_port.sv */
// six-bit bidirectional port with analog muxing behind an ahb-lite slave
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module sbpa_port import sbpa_pkg::*; #(
	parameter bit LARGE_PKG = 1'b1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [DATA_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [DATA_W-1:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [DATA_W-1:0] hrdata,
	input wire logic [PORT_W-1:0] pad_in,
	output logic [PORT_W-1:0] pad_out,
	output logic [PORT_W-1:0] pad_oe_n,
	input wire logic pmp_enable,
	input wire logic [1:0] pmp_data_out,
	input wire logic pmp_data_drive,
	output logic [1:0] pmp_data_in,
	output logic timer_external_clock_in,
	output logic [PORT_W-1:0] analog_enable,
	output logic comparator_reference_output
);

	logic [PORT_W-1:0] lat_reg;
	logic [PORT_W-1:0] dir_reg;
	logic [REG_W-1:0] ana_reg;
	logic [REG_W-1:0] def_reg;
	logic [REG_W-1:0] wdt_reg;
	logic [REG_W-1:0] cfg_reg;
	logic wr_pend_reg;
	logic [OFS_W-1:0] wr_ofs_reg;
	logic rd_pend_reg;
	logic [OFS_W-1:0] rd_ofs_reg;
	logic hreadyout_reg;
	logic [DATA_W-1:0] hrdata_reg;
	logic [PORT_W-1:0] pad_out_reg;
	logic [PORT_W-1:0] pad_oe_n_reg;
	logic [1:0] pmp_in_reg;
	logic tmr_reg;
	logic [PORT_W-1:0] ana_pin_reg;
	logic cref_out_reg;

	logic accept;
	logic wr_en;
	logic shared_sel;
	logic pmp_on;
	logic [PORT_W-1:0] ana_pin;
	logic [PORT_W-1:0] pin_read;
	logic [PORT_W-1:0] drive_n_next;
	logic [PORT_W-1:0] out_next;
	logic [REG_W-1:0] rd_byte;
	logic [REG_W-1:0] wbyte;

	assign accept = hsel && htrans == HTRANS_NONSEQ && hready;
	assign wr_en = wr_pend_reg;
	assign wbyte = hwdata[REG_W-1:0];
	assign shared_sel = wdt_reg[SHSEL_BIT];
	assign pmp_on = LARGE_PKG && !cfg_reg[CFG_PLACE_BIT] && pmp_enable;

	// channels 3..0 sit on pins 3..0, channel 4 on pin 5; select bit 0 = analog
	always_comb begin
		ana_pin = '0;
		ana_pin[3:0] = ~ana_reg[3:0];
		ana_pin[PMP_PIN_B] = ~ana_reg[ANA_CH_HI];
		// the reference output function on pin 2 counts as analog too
		ana_pin[CREF_PIN] = ana_pin[CREF_PIN] | cfg_reg[CFG_CREF_BIT];
	end

	// digital input path is cut on analog pins, so software reads zero
	always_comb begin
		pin_read = pad_in & ~ana_pin;
	end

	always_comb begin
		out_next = lat_reg;
		drive_n_next = dir_reg;
		if (pmp_on) begin
			out_next[PMP_PIN_A] = pmp_data_out[1];
			out_next[PMP_PIN_B] = pmp_data_out[0];
			drive_n_next[PMP_PIN_A] = !pmp_data_drive;
			drive_n_next[PMP_PIN_B] = !pmp_data_drive;
		end
		if (cfg_reg[CFG_CREF_BIT]) begin
			drive_n_next[CREF_PIN] = 1'b1;
		end
	end

	always_comb begin
		case (rd_ofs_reg)
		OFS_PIN: rd_byte = {2'h0, pin_read};
		OFS_LAT: rd_byte = {2'h0, lat_reg};
		OFS_DIR: rd_byte = {2'h0, dir_reg};
		OFS_SHARED: rd_byte = shared_sel ? ana_reg : def_reg;
		OFS_WDT: rd_byte = wdt_reg;
		OFS_CFG: rd_byte = cfg_reg;
		default: rd_byte = 8'h00;
		endcase
	end

	// bus phases: writes finish with no wait; reads add one wait cycle so
	// the answer is always registered and already sees a preceding write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg <= 8'h00;
			rd_pend_reg <= 1'b0;
			rd_ofs_reg <= 8'h00;
		end else begin
			wr_pend_reg <= accept && hwrite;
			rd_pend_reg <= accept && !hwrite;
			if (accept) begin
				wr_ofs_reg <= haddr[OFS_W-1:0];
				rd_ofs_reg <= haddr[OFS_W-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			if (accept && !hwrite) begin
				hreadyout_reg <= 1'b0;
			end else begin
				hreadyout_reg <= 1'b1;
			end
			if (rd_pend_reg) begin
				hrdata_reg <= {24'h00_0000, rd_byte};
			end
		end
	end

	// both the pin-level and the latch address land in the latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat_reg <= LAT_RST;
		end else if (wr_en && (wr_ofs_reg == OFS_PIN ||
			wr_ofs_reg == OFS_LAT)) begin
			lat_reg <= wbyte[PORT_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_reg <= DIR_RST;
		end else if (wr_en && wr_ofs_reg == OFS_DIR) begin
			dir_reg <= wbyte[PORT_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ana_reg <= ANA_RST;
			def_reg <= DEF_RST;
		end else if (wr_en && wr_ofs_reg == OFS_SHARED) begin
			if (shared_sel) begin
				ana_reg <= wbyte & ANA_MASK;
			end else begin
				def_reg <= wbyte;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_reg <= WDT_RST;
			cfg_reg <= CFG_RST;
		end else if (wr_en) begin
			if (wr_ofs_reg == OFS_WDT) begin
				wdt_reg <= wbyte & WDT_MASK;
			end
			if (wr_ofs_reg == OFS_CFG) begin
				cfg_reg <= wbyte & CFG_MASK;
			end
		end
	end

	// pins lag the registers by one cycle so every port leaves a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_out_reg <= LAT_RST;
			pad_oe_n_reg <= DIR_RST;
			ana_pin_reg <= {~ANA_RST[ANA_CH_HI], 1'b0, ~ANA_RST[3:0]};
			cref_out_reg <= 1'b0;
		end else begin
			pad_out_reg <= out_next;
			pad_oe_n_reg <= drive_n_next;
			ana_pin_reg <= ana_pin;
			cref_out_reg <= cfg_reg[CFG_CREF_BIT];
		end
	end

	// timer clock sees pin 4 whatever the direction, like the shared buffer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmr_reg <= 1'b0;
			pmp_in_reg <= 2'h0;
		end else begin
			tmr_reg <= pad_in[TMR_PIN];
			if (pmp_on) begin
				pmp_in_reg <= {pad_in[PMP_PIN_A], pad_in[PMP_PIN_B]};
			end else begin
				pmp_in_reg <= 2'h0;
			end
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign pad_out = pad_out_reg;
	assign pad_oe_n = pad_oe_n_reg;
	assign pmp_data_in = pmp_in_reg;
	assign timer_external_clock_in = tmr_reg;
	assign analog_enable = ana_pin_reg;
	assign comparator_reference_output = cref_out_reg;

	// checks
	logic first_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_write(logic [OFS_W-1:0] a);
		accept && hwrite && haddr[OFS_W-1:0] == a;
	endsequence

	sequence s_read(logic [OFS_W-1:0] a);
		accept && !hwrite && haddr[OFS_W-1:0] == a;
	endsequence

	a_drive_from_latch: assert property (
		!dir_reg[0] |=> !pad_oe_n[0] && pad_out[0] == $past(lat_reg[0]))
		else $error("output pin 0 not driven from latch");

	a_analog_reads_zero: assert property (
		s_read(OFS_PIN) ##1 !ana_reg[0] |=> hrdata[0] == 1'b0)
		else $error("analog pin 0 read as one");

	a_input_reads_pin: assert property (
		s_read(OFS_PIN) ##1 ana_reg[3] |=> hrdata[3] == $past(pad_in[3]))
		else $error("digital input 3 not read back");

	a_reset_analog: assert property (
		first_reg |-> ana_reg[4:0] == 5'h00 && analog_enable[3:0] == 4'hF)
		else $error("channels not analog after reset");

	a_timer_follows: assert property (
		!first_reg |=>
		timer_external_clock_in == $past(pad_in[TMR_PIN]))
		else $error("timer clock does not follow pin 4");

	a_cref_blocks: assert property (
		cfg_reg[CFG_CREF_BIT] |=> pad_oe_n[CREF_PIN] &&
		(rd_ofs_reg != OFS_PIN || !rd_pend_reg ||
		rd_byte[CREF_PIN] == 1'b0))
		else $error("pin 2 active with reference output on");

	a_placement_off: assert property (
		cfg_reg[CFG_PLACE_BIT] |=> pad_oe_n[PMP_PIN_A] ==
		$past(dir_reg[PMP_PIN_A]))
		else $error("master port used pins while placed elsewhere");

	a_pmp_direction: assert property (
		pmp_on && pmp_data_drive |=> !pad_oe_n[PMP_PIN_A] &&
		!pad_oe_n[PMP_PIN_B] && pad_out[PMP_PIN_A] == $past(pmp_data_out[1]))
		else $error("master port lost pin direction");

	a_upper_bits_zero: assert property (
		s_read(OFS_DIR) |=> ##1 hreadyout && hrdata[31:6] == 26'h0)
		else $error("unimplemented bits read non-zero");

	a_shared_gate: assert property (
		s_write(OFS_SHARED) ##1 !shared_sel |=> $stable(ana_reg))
		else $error("select register written while hidden");

	a_dir_to_pin: assert property (
		s_write(OFS_DIR) ##1 wbyte[1] |=> ##1 pad_oe_n[1])
		else $error("direction one did not make an input");

	a_latch_write: assert property (
		s_write(OFS_PIN) ##1 1'b1 |=> lat_reg == $past(wbyte[PORT_W-1:0]))
		else $error("pin-level write missed the latch");

	a_read_wait: assert property (
		accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read answer not after one wait");

	a_write_no_wait: assert property (
		accept && hwrite |=> hreadyout)
		else $error("write data phase stalled");

	// edge at which a read's answer is loaded into hrdata
	sequence s_read_answer(logic [OFS_W-1:0] a);
		s_read(a) ##1 1'b1;
	endsequence

	a_latch_readback: assert property (
		s_read_answer(OFS_LAT) |=>
		hrdata[PORT_W-1:0] == $past(lat_reg))
		else $error("latch read back wrong");

	a_dir_readback: assert property (
		s_read_answer(OFS_DIR) |=>
		hrdata[PORT_W-1:0] == $past(dir_reg))
		else $error("direction read back wrong");

	a_hidden_default: assert property (
		s_read(OFS_SHARED) ##1 !shared_sel |=>
		hrdata[REG_W-1:0] == $past(def_reg))
		else $error("hidden shared address not the default register");

	a_pin5_analog: assert property (
		s_read(OFS_PIN) ##1 !ana_reg[ANA_CH_HI] |=>
		hrdata[PMP_PIN_B] == 1'b0)
		else $error("analog pin 5 read as one");

	a_analog_select: assert property (
		!first_reg |=> analog_enable[1:0] == ~$past(ana_reg[1:0]) &&
		analog_enable[PMP_PIN_B] == !$past(ana_reg[ANA_CH_HI]))
		else $error("analog enable not following select bits");

	a_pin5_drive: assert property (
		!dir_reg[PMP_PIN_B] && !pmp_on |=> !pad_oe_n[PMP_PIN_B] &&
		pad_out[PMP_PIN_B] == $past(lat_reg[PMP_PIN_B]))
		else $error("output pin 5 not driven from latch");

	a_pmp_released: assert property (
		!pmp_on |=> pmp_data_in == 2'h0)
		else $error("master port input seen while not placed here");

	a_cref_follows: assert property (
		!first_reg |=> comparator_reference_output ==
		$past(cfg_reg[CFG_CREF_BIT]))
		else $error("reference output does not follow its enable");

endmodule // sbpa_port

/* testbench/sbpa_board.sv */
// board model that drives the port pins from outside
`timescale 1ns/1ps
module sbpa_board import sbpa_pkg::*; (
	input wire logic [PORT_W-1:0] pad_out,
	input wire logic [PORT_W-1:0] pad_oe_n,
	input wire logic [PORT_W-1:0] ext_val,
	output logic [PORT_W-1:0] pad_in
);
	// the board drives every pin the device releases, so no pin floats
	assign pad_in = (pad_out & ~pad_oe_n) | (ext_val & pad_oe_n);
endmodule // sbpa_board

/* testbench/six_bit_port_a_with_analog_muxing_tb.sv */
// self-checking bench of the six-bit port over ahb-lite
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module six_bit_port_a_with_analog_muxing_tb import sbpa_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic pmp_enable, pmp_data_drive, tclk, cref;
	logic [DATA_W-1:0] haddr, hwdata, hrdata, r, rl, rd_v, rs;
	logic [1:0] htrans, pmp_data_out, pmp_data_in;
	logic [2:0] hsize;
	logic [PORT_W-1:0] pad_in, pad_out, pad_oe_n, ext_val, ana_en, lvl;
	int error_cnt, checks, seed;
	sbpa_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pmp_enable(pmp_enable),
		.pmp_data_out(pmp_data_out), .pmp_data_drive(pmp_data_drive),
		.pmp_data_in(pmp_data_in), .timer_external_clock_in(tclk),
		.analog_enable(ana_en), .comparator_reference_output(cref));
	sbpa_board board (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.ext_val(ext_val), .pad_in(pad_in));
	function automatic logic [5:0] ae(input logic [31:0] s);
		// select bit 1 means digital; pin 4 has no converter channel
		return {~s[4], 1'b0, ~s[3:0]};
	endfunction
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] v);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		xfer(1'b1, a, d, v);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		xfer(1'b0, a, 32'h00000000, v);
	endtask
	task automatic settle();
		repeat (3) @(posedge hclk);
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		#50000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		{hsel, hwrite, pmp_enable, pmp_data_drive} = 4'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		pmp_data_out = 2'h0;
		seed = 32'hBCF0;
		ext_val = $random(seed);
		hresetn = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		settle();
		`CHK(pad_oe_n, 6'h3F)
		`CHK(ana_en, 6'h2F)
		`CHK(tclk, ext_val[4])
		rd(OFS_PIN, r);
		`CHK(r, {26'h0, ext_val & 6'h10})
		rd(OFS_DIR, r);
		`CHK(r, 32'h0000003F)
		wr(OFS_SHARED, 32'h5A);
		rd(OFS_SHARED, r);
		`CHK(r, 32'h0000005A)
		`CHK(hresp, 1'b0)
		`CHK(ana_en, 6'h2F)
		wr(OFS_WDT, 32'hFF);
		rd(OFS_WDT, r);
		`CHK(r, 32'h00000010)
		rd(OFS_SHARED, r);
		`CHK(r, 32'h00000000)
		repeat (20) begin
			rl = $random(seed);
			rd_v = $random(seed);
			rs = $random(seed);
			wr(OFS_LAT, rl);
			wr(OFS_DIR, rd_v);
			wr(OFS_SHARED, rs);
			ext_val <= $random(seed);
			settle();
			lvl = (rl[5:0] & ~rd_v[5:0]) | (ext_val & rd_v[5:0]);
			`CHK(pad_oe_n, rd_v[5:0])
			`CHK(pad_out & ~rd_v[5:0], rl[5:0] & ~rd_v[5:0])
			`CHK(ana_en, ae(rs))
			`CHK(tclk, lvl[4])
			rd(OFS_PIN, r);
			`CHK(r, {26'h0, lvl & ~ae(rs)})
			rd(OFS_LAT, r);
			`CHK(r, {26'h0, rl[5:0]})
			rd(OFS_DIR, r);
			`CHK(r, {26'h0, rd_v[5:0]})
			rd(OFS_SHARED, r);
			`CHK(r, rs & {24'h0, ANA_MASK})
		end
		wr(OFS_PIN, 32'hFFFFFF2A);
		rd(OFS_LAT, r);
		`CHK(r, 32'h0000002A)
		rd(8'h18, r);
		`CHK(r, 32'h00000000)
		wr(OFS_SHARED, 32'h1F);
		wr(OFS_LAT, 32'h3F);
		wr(OFS_DIR, 32'h00);
		wr(OFS_CFG, 32'h01);
		ext_val <= 6'h3F;
		settle();
		`CHK(cref, 1'b1)
		`CHK(pad_oe_n, 6'h04)
		`CHK(ana_en, 6'h04)
		rd(OFS_PIN, r);
		`CHK(r, 32'h0000003B)
		wr(OFS_CFG, 32'h00);
		wr(OFS_DIR, 32'h3F);
		pmp_enable <= 1'b1;
		pmp_data_drive <= 1'b1;
		pmp_data_out <= 2'b10;
		settle();
		`CHK(pad_oe_n, 6'h0F)
		`CHK(pad_out[5:4], 2'b01)
		pmp_data_drive <= 1'b0;
		ext_val <= 6'h10;
		settle();
		`CHK(pmp_data_in, 2'b10)
		wr(OFS_CFG, 32'h02);
		pmp_data_drive <= 1'b1;
		settle();
		`CHK(pad_oe_n, 6'h3F)
		`CHK(pmp_data_in, 2'b00)
		wrap_up();
	end
endmodule // six_bit_port_a_with_analog_muxing_tb
